// ==== hw/cpc_pkg.sv ====
// constants shared by the control port configuration block
package cpc_pkg;
    localparam logic [7:0] CPC_CTRL_OPT_ADDR = 8'h06;
    localparam logic [7:0] CPC_AUDIO_OPT_ADDR = 8'h07;
    localparam int CPC_LEGACY_INC_BIT = 4;
    localparam int CPC_PAGE_WRAP_BIT = 3;
    localparam int CPC_READ_DELAY_BIT = 2;
    localparam int CPC_PIN_FUNC_LSB = 0;
    localparam int CPC_DEEMPH_BIT = 4;
    localparam int CPC_SRC_SEL_BIT = 0;
    localparam logic [7:0] CPC_CTRL_OPT_MASK = 8'h1F;
    localparam logic [7:0] CPC_AUDIO_OPT_MASK = 8'h11;
    localparam logic [7:0] CPC_REG_RESET = 8'h00;
    localparam logic [1:0] CPC_PIN_FUNC_MISO = 2'h0;
    localparam logic [1:0] CPC_PIN_FUNC_GPIO = 2'h1;
    localparam logic [6:0] CPC_PAGE_LAST = 7'h7F;
    localparam logic [6:0] CPC_PAGE_RESTART = 7'h08;
    localparam logic [6:0] CPC_PAGE_FIRST = 7'h00;
    localparam logic [7:0] CPC_BOOK_ZERO = 8'h00;
    localparam logic [15:0] CPC_DEEMPH_B0_RESET = 16'h4000;
    localparam logic [15:0] CPC_DEEMPH_B1_RESET = 16'hE6A0;
    localparam logic [15:0] CPC_DEEMPH_A1_RESET = 16'h1A60;
endpackage

// ==== hw/cpc_addr_step.sv ====
// next register address for auto-increment with page wrap handling
`timescale 1ns/1ps
module cpc_addr_step
    import cpc_pkg::*;
(
    input wire logic [7:0] book,
    input wire logic [7:0] page,
    input wire logic [6:0] addr,
    input wire logic page_wrap_disable,
    output logic [7:0] next_page,
    output logic [6:0] next_addr
);
    always_comb begin
        next_page = page;
        next_addr = addr + 7'h01;
        if (book != CPC_BOOK_ZERO && addr == CPC_PAGE_LAST) begin
            if (page_wrap_disable) begin
                next_addr = CPC_PAGE_FIRST;
            end else begin
                next_page = page + 8'h01;
                next_addr = CPC_PAGE_RESTART;
            end
        end
    end
endmodule

// ==== hw/cpc_deemph.sv ====
// first order de-emphasis filter with writable coefficients
`timescale 1ns/1ps
module cpc_deemph
    import cpc_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic sample_valid,
    input wire logic [15:0] sample_in,
    input wire logic coef_we,
    input wire logic [1:0] coef_addr,
    input wire logic [15:0] coef_data,
    output logic [15:0] sample_out
);
    typedef struct packed {
        logic [2:0][15:0] coef;
        logic [15:0] x1;
        logic [15:0] y1;
    } cpc_deemph_state_type;
    cpc_deemph_state_type st, next_st;
    logic signed [33:0] acc;

    function automatic logic signed [33:0] mul(input logic [15:0] a, input logic [15:0] b);
        mul = 34'($signed(a) * $signed(b));
    endfunction

    always_comb begin
        next_st = st;
        acc = mul(st.coef[0], sample_in) + mul(st.coef[1], st.x1) + mul(st.coef[2], st.y1);
        if (sample_valid) begin
            next_st.x1 = sample_in;
            next_st.y1 = acc[29:14];
        end
        if (coef_we && coef_addr != 2'h3) begin
            next_st.coef[coef_addr] = coef_data;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            st.coef <= {CPC_DEEMPH_A1_RESET, CPC_DEEMPH_B1_RESET, CPC_DEEMPH_B0_RESET};
            st.x1 <= 16'h0000;
            st.y1 <= 16'h0000;
        end else begin
            st <= next_st;
        end
    end
    assign sample_out = st.y1;
endmodule

// ==== hw/cpc_config_regs.sv ====
// control port and audio path configuration registers 0x06 and 0x07
`timescale 1ns/1ps
// What this block does
// - legacy bit clear: address always increments after each byte
// - legacy bit set: two-wire transfers increment only when address byte msb is set, spi transfers always increment
// - wrap enabled: non-zero book page end continues at address 8 of next page
// - wrap disabled: non-zero book page end returns to address 0 same page
// - serial reads in non-zero books return data one frame late
// - read delay bit adds that frame delay to first book reads too
// - pin function 00 gives miso output on spi transfers only, 01 gives general pin
// - general pin function stops register read data on the pin
// - de-emphasis bit inserts the filter when set, bypasses when clear
// - filter default coefficients suit 44.1 kHz and are rewritable
// - source bit routes processed output when 0, raw input when 1
module cpc_config_regs
    import cpc_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic reg_we,
    input wire logic reg_re,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic xfer_start,
    input wire logic xfer_spi,
    input wire logic [7:0] start_book,
    input wire logic [7:0] start_page,
    input wire logic [7:0] addr_byte,
    input wire logic byte_done,
    input wire logic frame_tick,
    input wire logic [7:0] mem_rdata,
    output logic [7:0] cur_book,
    output logic [7:0] cur_page,
    output logic [6:0] cur_addr,
    output logic miso_out,
    output logic miso_oe,
    output logic general_pin_three_out,
    output logic general_pin_three_oe,
    input wire logic general_pin_three_level,
    input wire logic spi_read_bit,
    input wire logic sample_valid,
    input wire logic [15:0] dsp_input,
    input wire logic [15:0] dsp_output,
    input wire logic coef_we,
    input wire logic [1:0] coef_addr,
    input wire logic [15:0] coef_data,
    output logic [15:0] audio_path_sample,
    output logic serial_audio_output,
    output logic general_pin_level
);
    import cpc_pkg::*;

    typedef struct packed {
        logic [7:0] ctrl_opt;
        logic [7:0] audio_opt;
        logic [7:0] rdata;
        logic [7:0] book;
        logic [7:0] page;
        logic [6:0] addr;
        logic auto_inc;
        logic delay_pending;
        logic [7:0] held_data;
        logic miso;
        logic miso_en;
        logic gp_out;
        logic gp_en;
        logic [15:0] sample;
        logic sdo;
        logic gp_level;
    } cpc_regs_state_type;

    cpc_regs_state_type st, next_st;
    logic [7:0] step_page;
    logic [6:0] step_addr;
    logic [15:0] filtered;
    logic legacy_increment_mode;
    logic page_wrap_disable;
    logic book_zero_read_delay;
    logic [1:0] serial_out_pin_function;
    logic deemphasis_enable;
    logic audio_out_source_select;
    logic [15:0] audio_src;
    logic [1:0] addr_hit;
    logic [1:0] pin_en;

    function automatic logic [7:0] reg_read(input logic [7:0] a, input logic [7:0] c, input logic [7:0] p);
        if (a == CPC_CTRL_OPT_ADDR) begin
            reg_read = c & CPC_CTRL_OPT_MASK;
        end else if (a == CPC_AUDIO_OPT_ADDR) begin
            reg_read = p & CPC_AUDIO_OPT_MASK;
        end else begin
            reg_read = 8'h00;
        end
    endfunction

    // one-hot decode of the two mapped offsets, shared by both write strobes
    function automatic logic [1:0] reg_hit(input logic [7:0] a);
        reg_hit = 2'h0;
        if (a == CPC_CTRL_OPT_ADDR) begin
            reg_hit[0] = 1'h1;
        end
        if (a == CPC_AUDIO_OPT_ADDR) begin
            reg_hit[1] = 1'h1;
        end
    endfunction

    // reserved bits never store, so they read back as zero
    function automatic logic [7:0] masked_write(input logic [7:0] d, input logic [7:0] m);
        masked_write = d & m;
    endfunction

    // the address msb only matters for the two-wire port in legacy mode
    function automatic logic increment_wanted(input logic legacy, input logic spi, input logic [7:0] ab);
        if (legacy && !spi) begin
            increment_wanted = ab[7];
        end else begin
            increment_wanted = 1'h1;
        end
    endfunction

    // delayed path: every non-zero book, and the first book when the delay bit asks
    function automatic logic read_delayed(input logic [7:0] bk, input logic delay_bit);
        read_delayed = bk != CPC_BOOK_ZERO || delay_bit;
    endfunction

    // {general pin enable, data pin enable}; reserved codes leave both pins undriven
    function automatic logic [1:0] pin_enables(input logic [1:0] func, input logic spi);
        unique case (func)
            CPC_PIN_FUNC_MISO: begin
                pin_enables = {1'h0, spi};
            end
            CPC_PIN_FUNC_GPIO: begin
                pin_enables = 2'h2;
            end
            default: begin
                pin_enables = 2'h0;
            end
        endcase
    endfunction

    function automatic logic serial_audio_output_bit(input logic [15:0] raw, input logic [15:0] f,
                                                     input logic en);
        serial_audio_output_bit = en ? f[15] : raw[15];
    endfunction

    assign legacy_increment_mode = st.ctrl_opt[CPC_LEGACY_INC_BIT];
    assign page_wrap_disable = st.ctrl_opt[CPC_PAGE_WRAP_BIT];
    assign book_zero_read_delay = st.ctrl_opt[CPC_READ_DELAY_BIT];
    assign serial_out_pin_function = st.ctrl_opt[CPC_PIN_FUNC_LSB +: 2];
    assign deemphasis_enable = st.audio_opt[CPC_DEEMPH_BIT];
    assign audio_out_source_select = st.audio_opt[CPC_SRC_SEL_BIT];
    // source choice precedes the filter so both paths see the same selection
    assign audio_src = audio_out_source_select ? dsp_input : dsp_output;
    assign addr_hit = reg_hit(reg_addr);
    assign pin_en = pin_enables(serial_out_pin_function, xfer_spi);

    cpc_addr_step u_step (
        .book(st.book),
        .page(st.page),
        .addr(st.addr),
        .page_wrap_disable(page_wrap_disable),
        .next_page(step_page),
        .next_addr(step_addr)
    );

    cpc_deemph u_deemph (
        .mclk(mclk),
        .nrst(nrst),
        .sample_valid(sample_valid),
        .sample_in(audio_src),
        .coef_we(coef_we),
        .coef_addr(coef_addr),
        .coef_data(coef_data),
        .sample_out(filtered)
    );

    always_comb begin
        next_st = st;
        // one decoder for both offsets so a write can never land in two registers
        if (reg_we && addr_hit[0]) begin
            next_st.ctrl_opt = masked_write(reg_wdata, CPC_CTRL_OPT_MASK);
        end
        if (reg_we && addr_hit[1]) begin
            next_st.audio_opt = masked_write(reg_wdata, CPC_AUDIO_OPT_MASK);
        end
        if (reg_re) begin
            next_st.rdata = reg_read(reg_addr, st.ctrl_opt, st.audio_opt);
        end
        if (xfer_start) begin
            next_st.book = start_book;
            next_st.page = start_page;
            next_st.addr = addr_byte[6:0];
            next_st.auto_inc = increment_wanted(legacy_increment_mode, xfer_spi, addr_byte);
        end else if (byte_done && st.auto_inc) begin
            next_st.page = step_page;
            next_st.addr = step_addr;
        end
        // serial read data: one frame late outside the first book, or inside it when asked
        if (frame_tick) begin
            next_st.held_data = mem_rdata;
            next_st.delay_pending = 1'b1;
        end
        if (read_delayed(st.book, book_zero_read_delay)) begin
            next_st.miso = st.delay_pending ? st.held_data[7] : 1'b0;
        end else begin
            next_st.miso = spi_read_bit;
        end
        if (xfer_start) begin
            next_st.delay_pending = 1'b0;
        end
        next_st.miso_en = pin_en[0];
        next_st.gp_en = pin_en[1];
        // data pin idles low whenever its driver is off, so the output stays a plain flop
        if (!next_st.miso_en) begin
            next_st.miso = 1'h0;
        end
        next_st.gp_out = serial_audio_output_bit(audio_src, filtered, deemphasis_enable);
        next_st.sample = deemphasis_enable ? filtered : audio_src;
        next_st.sdo = next_st.sample[15];
        next_st.gp_level = general_pin_three_level;
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata = st.rdata;
    assign cur_book = st.book;
    assign cur_page = st.page;
    assign cur_addr = st.addr;
    assign miso_out = st.miso;
    assign miso_oe = st.miso_en;
    assign general_pin_three_out = st.gp_out;
    assign general_pin_three_oe = st.gp_en;
    assign audio_path_sample = st.sample;
    assign serial_audio_output = st.sdo;
    assign general_pin_level = st.gp_level;
endmodule

// ==== bench/cpc_sva.sv ====
// checker on the configuration register block ports
`timescale 1ns/1ps
module cpc_sva
    import cpc_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic reg_we,
    input wire logic reg_re,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic xfer_start,
    input wire logic xfer_spi,
    input wire logic [7:0] start_book,
    input wire logic [7:0] start_page,
    input wire logic [7:0] addr_byte,
    input wire logic byte_done,
    input wire logic [7:0] cur_book,
    input wire logic [7:0] cur_page,
    input wire logic [6:0] cur_addr,
    input wire logic miso_oe,
    input wire logic general_pin_three_oe
);
    logic [1:0] pin_func;
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    // shadow of the pin function field as last written
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            pin_func <= 2'h0;
        end else if (reg_we && reg_addr == CPC_CTRL_OPT_ADDR) begin
            pin_func <= reg_wdata[1:0];
        end
    end
    ctrl_mask_a:
    assert property (reg_re && reg_addr == CPC_CTRL_OPT_ADDR |=> (reg_rdata & ~CPC_CTRL_OPT_MASK) == 8'h00)
        else $error("reserved control bits read nonzero");
    unmapped_read_a:
    assert property (reg_re && reg_addr != CPC_CTRL_OPT_ADDR && reg_addr != CPC_AUDIO_OPT_ADDR |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    write_readback_a:
    assert property (reg_we && reg_addr == CPC_CTRL_OPT_ADDR ##1 reg_re && !reg_we && reg_addr == CPC_CTRL_OPT_ADDR
        |=> reg_rdata == ($past(reg_wdata, 2) & CPC_CTRL_OPT_MASK)) else $error("control readback wrong");
    read_hold_a:
    assert property (!reg_re |=> $stable(reg_rdata)) else $error("read data moved without a read");
    pointer_load_a:
    assert property (xfer_start |=> cur_book == $past(start_book) && cur_page == $past(start_page)
        && {1'b0, cur_addr} == ($past(addr_byte) & 8'h7F)) else $error("pointer not loaded");
    spi_step_a:
    assert property (byte_done && xfer_spi && !xfer_start && cur_addr != CPC_PAGE_LAST
        |=> cur_addr == $past(cur_addr) + 7'h01) else $error("spi pointer did not step");
    gpio_quiet_a:
    assert property ($past(pin_func) != CPC_PIN_FUNC_MISO && pin_func != CPC_PIN_FUNC_MISO |-> !miso_oe)
        else $error("data pin driven as general pin");
    gpio_off_a:
    assert property ($past(pin_func) != CPC_PIN_FUNC_GPIO && pin_func != CPC_PIN_FUNC_GPIO |-> !general_pin_three_oe)
        else $error("general pin driven in data mode");
    cover property (reg_we && reg_addr == CPC_CTRL_OPT_ADDR ##1 reg_re);
    cover property (xfer_start ##1 byte_done);
    cover property (byte_done && cur_addr == CPC_PAGE_LAST);
endmodule
bind cpc_config_regs cpc_sva sva_u (
    .mclk(mclk),
    .nrst(nrst),
    .reg_we(reg_we),
    .reg_re(reg_re),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .xfer_start(xfer_start),
    .xfer_spi(xfer_spi),
    .start_book(start_book),
    .start_page(start_page),
    .addr_byte(addr_byte),
    .byte_done(byte_done),
    .cur_book(cur_book),
    .cur_page(cur_page),
    .cur_addr(cur_addr),
    .miso_oe(miso_oe),
    .general_pin_three_oe(general_pin_three_oe)
);

// ==== bench/cpc_host_model.sv ====
// host side model: frame ticks and memory read bytes
`timescale 1ns/1ps
module cpc_host_model (
    input wire logic mclk,
    input wire logic nrst,
    output logic frame_tick,
    output logic [7:0] mem_rdata
);
    logic [3:0] cnt;
    logic [7:0] frames;
    // frames sit well apart so a read always leaves room for the one-frame delay
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            cnt <= 4'h0;
            frames <= 8'h00;
        end else begin
            cnt <= cnt + 4'h1;
            frames <= frames + {7'h00, cnt == 4'hF};
        end
    end
    assign frame_tick = cnt == 4'hF;
    // byte differs every frame, though its msb, the only bit the pin shows, changes once per 128 frames
    assign mem_rdata = frames ^ 8'hA5;
endmodule

// ==== bench/testbench.sv ====
// self-checking bench for the configuration register block
`timescale 1ns/1ps
module testbench;
    import cpc_pkg::*;
    logic mclk = 1'h0, nrst = 1'h0, reg_we = 1'h0, reg_re = 1'h0, xfer_start = 1'h0, xfer_spi = 1'h0;
    logic byte_done = 1'h0, frame_tick, miso_out, miso_oe, general_pin_three_out, general_pin_three_oe;
    logic general_pin_three_level = 1'h0, spi_read_bit = 1'h0, sample_valid = 1'h0, coef_we = 1'h0;
    logic serial_audio_output, general_pin_level;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, start_book = 8'h00, start_page = 8'h00;
    logic [7:0] addr_byte = 8'h00, mem_rdata, cur_book, cur_page;
    logic [6:0] cur_addr;
    logic [1:0] coef_addr = 2'h0;
    logic [15:0] dsp_input = 16'h9234, dsp_output = 16'h5678, coef_data = 16'h0000, audio_path_sample;
    int num_errors = 0, comparisons = 0;
    cpc_config_regs dut_u (
        .mclk(mclk),
        .nrst(nrst),
        .reg_we(reg_we),
        .reg_re(reg_re),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata),
        .xfer_start(xfer_start),
        .xfer_spi(xfer_spi),
        .start_book(start_book),
        .start_page(start_page),
        .addr_byte(addr_byte),
        .byte_done(byte_done),
        .frame_tick(frame_tick),
        .mem_rdata(mem_rdata),
        .cur_book(cur_book),
        .cur_page(cur_page),
        .cur_addr(cur_addr),
        .miso_out(miso_out),
        .miso_oe(miso_oe),
        .general_pin_three_out(general_pin_three_out),
        .general_pin_three_oe(general_pin_three_oe),
        .general_pin_three_level(general_pin_three_level),
        .spi_read_bit(spi_read_bit),
        .sample_valid(sample_valid),
        .dsp_input(dsp_input),
        .dsp_output(dsp_output),
        .coef_we(coef_we),
        .coef_addr(coef_addr),
        .coef_data(coef_data),
        .audio_path_sample(audio_path_sample),
        .serial_audio_output(serial_audio_output),
        .general_pin_level(general_pin_level)
    );
    cpc_host_model host_u (.mclk(mclk), .nrst(nrst), .frame_tick(frame_tick), .mem_rdata(mem_rdata));
    always #4 mclk = ~mclk;
    task automatic chk(input string what, input logic [15:0] exp, got);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        reg_we = 1'h1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge mclk);
        reg_we = 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, e);
        reg_re = 1'h1;
        reg_addr = a;
        @(negedge mclk);
        reg_re = 1'h0;
        @(negedge mclk);
        chk("reg_rdata", {8'h00, e}, {8'h00, reg_rdata});
    endtask
    task automatic step();
        byte_done = 1'h1;
        @(negedge mclk);
        byte_done = 1'h0;
    endtask
    task automatic xfer(input logic spi, input logic [7:0] pg, ab, epg, input logic [6:0] ead);
        xfer_start = 1'h1;
        xfer_spi = spi;
        start_book = {7'h00, spi};
        start_page = pg;
        addr_byte = ab;
        @(negedge mclk);
        xfer_start = 1'h0;
        step();
        chk("cur_page", {8'h00, epg}, {8'h00, cur_page});
        chk("cur_addr", {9'h000, ead}, {9'h000, cur_addr});
    endtask
    task automatic play(input logic [15:0] e);
        sample_valid = 1'h1;
        @(negedge mclk);
        sample_valid = 1'h0;
        repeat (4) @(negedge mclk);
        chk("audio_path_sample", e, audio_path_sample);
        chk("serial_audio_output", {15'h0000, e[15]}, {15'h0000, serial_audio_output});
        chk("general_pin_three_out", {15'h0000, e[15]}, {15'h0000, general_pin_three_out});
    endtask
    // delayed read path: the byte taken at a frame tick shows its msb two edges later
    task automatic held_bit_check();
        logic e;
        spi_read_bit = 1'h0;
        while (!frame_tick) begin
            @(negedge mclk);
        end
        e = mem_rdata[7];
        repeat (2) @(negedge mclk);
        chk("miso_out", {15'h0000, e}, {15'h0000, miso_out});
    endtask
    task automatic report_and_stop();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        #200000;
        num_errors++;
        report_and_stop();
    end
    initial begin
        repeat (8) @(negedge mclk);
        nrst = 1'h1;
        rd(CPC_CTRL_OPT_ADDR, 8'h00);
        rd(CPC_AUDIO_OPT_ADDR, 8'h00);
        general_pin_three_level = 1'h1;
        wr(CPC_CTRL_OPT_ADDR, 8'hFD);
        rd(CPC_CTRL_OPT_ADDR, 8'h1D);
        wr(CPC_AUDIO_OPT_ADDR, 8'hFF);
        rd(CPC_AUDIO_OPT_ADDR, 8'h11);
        wr(8'h05, 8'hFF);
        rd(8'h05, 8'h00);
        xfer(1'h1, 8'h02, 8'h7F, 8'h02, 7'h00);
        chk("miso_oe", 16'h0000, {15'h0000, miso_oe});
        chk("general_pin_three_oe", 16'h0001, {15'h0000, general_pin_three_oe});
        chk("general_pin_level", 16'h0001, {15'h0000, general_pin_level});
        wr(CPC_CTRL_OPT_ADDR, 8'h00);
        xfer(1'h1, 8'h02, 8'h7F, 8'h03, 7'h08);
        step();
        chk("cur_addr", 16'h0009, {9'h000, cur_addr});
        chk("general_pin_three_oe", 16'h0000, {15'h0000, general_pin_three_oe});
        chk("miso_oe", 16'h0001, {15'h0000, miso_oe});
        held_bit_check();
        xfer(1'h0, 8'h00, 8'h05, 8'h00, 7'h06);
        xfer_spi = 1'h1;
        spi_read_bit = 1'h1;
        repeat (2) @(negedge mclk);
        chk("miso_out", 16'h0001, {15'h0000, miso_out});
        wr(CPC_CTRL_OPT_ADDR, 8'h04);
        held_bit_check();
        wr(CPC_CTRL_OPT_ADDR, 8'h10);
        xfer(1'h0, 8'h00, 8'h05, 8'h00, 7'h05);
        xfer(1'h0, 8'h00, 8'h85, 8'h00, 7'h06);
        wr(CPC_AUDIO_OPT_ADDR, 8'h01);
        play(16'h9234);
        wr(CPC_AUDIO_OPT_ADDR, 8'h00);
        play(16'h5678);
        for (int i = 0; i < 3; i++) begin
            coef_we = 1'h1;
            coef_addr = 2'(i);
            coef_data = (i == 0) ? 16'h2000 : 16'h0000;
            @(negedge mclk);
        end
        coef_we = 1'h0;
        wr(CPC_AUDIO_OPT_ADDR, 8'h10);
        play(16'h2B3C);
        report_and_stop();
    end
endmodule
